// File: core/otp_access_pkg.sv
// package: constants for the one-time program memory write/verify access block
package otp_access_pkg;

    // ************************************************************
    // memory geometry
    // ************************************************************
    localparam int unsigned WORD_COUNT      = 512;
    localparam int unsigned WORD_WIDTH      = 16;
    localparam int unsigned ADDR_WIDTH      = 9;
    localparam int unsigned STEP_PER_WORD   = 4;

    // ************************************************************
    // run mode pin codes, bit i is run_mode_sel i
    // ************************************************************
    localparam logic [3:0] MODE_CLEAR_CODE   = 4'h5;   // sel0=H sel1=L sel2=H sel3=L
    localparam logic [3:0] MODE_WRITE_CODE   = 4'hE;   // L H H H
    localparam logic [3:0] MODE_VERIFY_CODE  = 4'hC;   // L L H H
    localparam logic [3:0] MODE_INHIBIT_MASK = 4'hD;   // sel1 is don't care
    localparam logic [3:0] MODE_INHIBIT_CODE = 4'hD;   // H x H H

    typedef enum logic [2:0] {
        RUN_IDLE    = 3'b000,
        RUN_CLEAR   = 3'b001,
        RUN_WRITE   = 3'b010,
        RUN_VERIFY  = 3'b011,
        RUN_INHIBIT = 3'b100
    } run_mode_t;

    // ************************************************************
    // ahb-lite register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  REG_CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  REG_STATUS_OFFSET = 8'h04;
    localparam logic [7:0]  REG_ADDR_OFFSET   = 8'h08;
    localparam logic [7:0]  REG_DATA_OFFSET   = 8'h0C;
    localparam int unsigned CTRL_ENTRY_BIT    = 0;
    localparam int unsigned CTRL_CPU_RD_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET_VALUE  = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_SYS_HZ        = 25_000_000;
    localparam int unsigned RESET_HOLD_US     = 10;
    localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_US * (CLK_SYS_HZ / 1_000_000));

endpackage : otp_access_pkg

// File: core/otp_sync2.sv
// module: two flip-flop level synchroniser, parameterised width
module otp_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset of the destination domain
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : otp_sync2

// File: core/otp_program_memory_access.sv
// module: one-time program memory with pin-driven write/verify access and ahb-lite view
module otp_program_memory_access #(
    parameter int unsigned WORDS       = otp_access_pkg::WORD_COUNT,
    parameter int unsigned RESET_HOLD  = otp_access_pkg::RESET_HOLD_CYCLES
) (
    // system clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // programming supply pins, seen as levels
    input  wire logic        reset_pin_n_i,
    input  wire logic        prog_supply_i,
    // address step clock pin, second clock domain
    input  wire logic        addr_step_clock_pin_i,
    // mode pins: port b 0..2 and second oscillator pin
    input  wire logic [2:0]  open_drain_port_b_i,
    input  wire logic        osc_second_pin_i,
    // data bus: port c high nibble, port d low nibble
    input  wire logic [3:0]  push_pull_port_c_i,
    output logic      [3:0]  push_pull_port_c_o,
    output logic      [3:0]  push_pull_port_c_oe_o,
    input  wire logic [3:0]  push_pull_port_d_i,
    output logic      [3:0]  push_pull_port_d_o,
    output logic      [3:0]  push_pull_port_d_oe_o,
    // status
    output logic             prog_mode_o
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    initial begin
        if (WORDS != otp_access_pkg::WORD_COUNT) begin
            $error("WORDS must equal the fixed memory size");
        end
        if (RESET_HOLD < 1) begin
            $error("RESET_HOLD must be at least one cycle");
        end
    end

    localparam int unsigned AW = otp_access_pkg::ADDR_WIDTH;
    localparam int unsigned DW = otp_access_pkg::WORD_WIDTH;

    // ************************************************************
    // pin synchronisers into the system domain
    // ************************************************************
    logic [1:0] pwr_sync;
    otp_sync2 #(.WIDTH(2)) u_pwr_sync (
        .clk_i   (clk_sys_i),
        .rst_i   (rst_i),
        .async_i ({reset_pin_n_i, prog_supply_i}),
        .sync_o  (pwr_sync)
    );
    wire reset_held_s = ~pwr_sync[1];
    wire supply_on_s  = pwr_sync[0];

    // ************************************************************
    // entry into programming mode (system domain)
    // ************************************************************
    logic [31:0] hold_cnt_ff;
    logic        armed_ff;
    logic        prog_mode_ff;
    logic        entry_en_ff;     // software must allow entry; the reset value forbids it
    logic        cpu_rd_ff;       // software read bit, only stored and read back; data slot reads zero

    wire hold_done = (hold_cnt_ff >= RESET_HOLD);
    wire [31:0] nxt_hold_cnt = reset_held_s ? (hold_done ? hold_cnt_ff : hold_cnt_ff + 32'h0000_0001)
                                            : 32'h0000_0000;
    // armed only once reset has been held long enough before the supply rises
    wire nxt_armed = reset_held_s & ~supply_on_s & hold_done ? 1'b1 :
                     (~supply_on_s & ~reset_held_s) ? 1'b0 : armed_ff;
    wire nxt_prog_mode = supply_on_s & (armed_ff | prog_mode_ff) & entry_en_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt_ff  <= 32'h0000_0000;
            armed_ff     <= 1'b0;
            prog_mode_ff <= 1'b0;
        end else begin
            hold_cnt_ff  <= nxt_hold_cnt;
            armed_ff     <= nxt_armed;
            prog_mode_ff <= nxt_prog_mode;
        end
    end
    assign prog_mode_o = prog_mode_ff;

    // enable level handed into the link domain
    logic link_en_s;
    otp_sync2 #(.WIDTH(1)) u_en_sync (
        .clk_i   (addr_step_clock_pin_i),
        .rst_i   (rst_i),
        .async_i (prog_mode_ff),
        .sync_o  (link_en_s)
    );

    // ************************************************************
    // mode decode (pins are quasi-static around step pulses)
    // ************************************************************
    wire [3:0] mode_pins = {osc_second_pin_i, open_drain_port_b_i};
    wire is_clear   = (mode_pins == otp_access_pkg::MODE_CLEAR_CODE);
    wire is_write   = (mode_pins == otp_access_pkg::MODE_WRITE_CODE);
    wire is_verify  = (mode_pins == otp_access_pkg::MODE_VERIFY_CODE);
    wire is_inhibit = ((mode_pins & otp_access_pkg::MODE_INHIBIT_MASK)
                       == otp_access_pkg::MODE_INHIBIT_CODE);
    otp_access_pkg::run_mode_t run_mode;
    always_comb begin
        case (1'b1)
            is_clear:   run_mode = otp_access_pkg::RUN_CLEAR;
            is_write:   run_mode = otp_access_pkg::RUN_WRITE;
            is_verify:  run_mode = otp_access_pkg::RUN_VERIFY;
            is_inhibit: run_mode = otp_access_pkg::RUN_INHIBIT;
            default:    run_mode = otp_access_pkg::RUN_IDLE;
        endcase
    end

    // ************************************************************
    // link domain: address counter, word assembly, programming
    // ************************************************************
    logic [DW-1:0] mem [WORDS];
    logic [AW-1:0] addr_ff;
    logic [1:0]    step_ff;
    logic [7:0]    hi_byte_ff;
    logic [AW-1:0] tog_addr_ff;            // address of last programmed word
    logic          wr_tog_ff;

    wire [7:0]  bus_in   = {push_pull_port_c_i, push_pull_port_d_i};
    wire        live     = link_en_s;
    wire        clr_now  = live & (run_mode == otp_access_pkg::RUN_CLEAR);
    wire        wr_now   = live & (run_mode == otp_access_pkg::RUN_WRITE);
    // clocks in clear mode keep the counter at zero
    wire        step_adv = live & (run_mode != otp_access_pkg::RUN_CLEAR)
                          & (run_mode != otp_access_pkg::RUN_IDLE);
    wire        last_step = (step_ff == 2'(otp_access_pkg::STEP_PER_WORD - 1));
    wire [AW-1:0] nxt_addr = clr_now ? '0 :
                             (step_adv & last_step) ? addr_ff + AW'(1) : addr_ff;
    wire [1:0]  nxt_step = clr_now ? 2'h0 : (step_adv ? step_ff + 2'h1 : step_ff);

    // counter: four pulses per word, cleared by the clear code
    always_ff @(posedge addr_step_clock_pin_i or posedge rst_i) begin
        if (rst_i) begin
            addr_ff <= '0;
            step_ff <= 2'h0;
        end else begin
            addr_ff <= nxt_addr;
            step_ff <= nxt_step;
        end
    end

    // high byte taken on pulse 0, word burned on pulse 1; one-time cells only clear to zero
    always_ff @(posedge addr_step_clock_pin_i or posedge rst_i) begin
        if (rst_i) begin
            hi_byte_ff  <= 8'h00;
            tog_addr_ff <= '0;
            wr_tog_ff   <= 1'b0;
        end else begin
            if (wr_now && step_ff == 2'h0) begin
                hi_byte_ff <= bus_in;
            end
            if (wr_now && step_ff == 2'h1) begin
                tog_addr_ff <= addr_ff;
                wr_tog_ff   <= ~wr_tog_ff;
            end
        end
    end

    // ************************************************************
    // one-time cells: never-written words read blank
    // ************************************************************
    logic [WORDS-1:0] used_ff;             // word burned at least once
    wire  [DW-1:0]    new_word  = {hi_byte_ff, bus_in};
    wire              burn_now  = wr_now & (step_ff == 2'h1);
    // cells only clear to zero, so a repeated write can never raise a bit
    wire  [DW-1:0]    burn_word = used_ff[addr_ff] ? (mem[addr_ff] & new_word) : new_word;

    // blank marks live in flops so the array itself needs no reset;
    // limitation: a reset forgets which words were burned
    always_ff @(posedge addr_step_clock_pin_i or posedge rst_i) begin
        if (rst_i) begin
            used_ff <= '0;
        end else if (burn_now) begin
            used_ff[addr_ff] <= 1'b1;
        end
    end

    // memory array, no reset
    always_ff @(posedge addr_step_clock_pin_i) begin
        if (burn_now) begin
            mem[addr_ff] <= burn_word;
        end
    end

    // ************************************************************
    // verify read-out onto the bus
    // ************************************************************
    // a blank word shows all ones instead of an unknown array cell
    wire [DW-1:0] rd_word  = used_ff[addr_ff] ? mem[addr_ff] : '1;
    wire          drive_on = live & (run_mode == otp_access_pkg::RUN_VERIFY);
    // steps 0/1 show the high byte, steps 2/3 the low byte
    wire [7:0]    rd_byte  = step_ff[1] ? rd_word[7:0] : rd_word[15:8];
    logic [7:0] out_ff;
    logic       oe_ff;
    always_ff @(posedge addr_step_clock_pin_i or posedge rst_i) begin
        if (rst_i) begin
            out_ff <= 8'h00;
            oe_ff  <= 1'b0;
        end else begin
            out_ff <= rd_byte;
            oe_ff  <= drive_on;
        end
    end
    // enable drops at once when the mode leaves verify, avoiding bus fights
    wire oe_now = oe_ff & drive_on;
    assign push_pull_port_c_o    = out_ff[7:4];
    assign push_pull_port_d_o    = out_ff[3:0];
    assign push_pull_port_c_oe_o = {4{oe_now}};
    assign push_pull_port_d_oe_o = {4{oe_now}};

    // ************************************************************
    // crossing of program events and address into system domain
    // ************************************************************
    logic [2:0]    tog_sync_ff;
    logic [AW-1:0] last_addr_ff;
    logic [15:0]   wr_count_ff;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tog_sync_ff <= 3'h0;
        end else begin
            tog_sync_ff <= {tog_sync_ff[1:0], wr_tog_ff};
        end
    end
    wire wr_event = tog_sync_ff[2] ^ tog_sync_ff[1];
    // address is stable for many system cycles after the toggle is seen;
    // limitation: burns must be at least three system cycles apart, which
    // any real write pulse easily is, or toggles cancel and counts are lost
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            last_addr_ff <= '0;
            wr_count_ff  <= 16'h0000;
        end else if (wr_event) begin
            last_addr_ff <= tog_addr_ff;
            wr_count_ff  <= wr_count_ff + 16'h0001;
        end
    end

    // ************************************************************
    // ahb-lite slave: zero wait states, always okay
    // ************************************************************
    logic       dp_valid_ff;
    logic       dp_write_ff;
    logic [7:0] dp_addr_ff;
    wire addr_phase = hsel_i & hready_i & (htrans_i == otp_access_pkg::HTRANS_NONSEQ);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 8'h00;
        end else begin
            dp_valid_ff <= addr_phase;
            dp_write_ff <= hwrite_i;
            dp_addr_ff  <= haddr_i[7:0];
        end
    end

    wire ctrl_wr = dp_valid_ff & dp_write_ff & (dp_addr_ff == otp_access_pkg::REG_CTRL_OFFSET);
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            entry_en_ff <= otp_access_pkg::CTRL_RESET_VALUE[otp_access_pkg::CTRL_ENTRY_BIT];
            cpu_rd_ff   <= otp_access_pkg::CTRL_RESET_VALUE[otp_access_pkg::CTRL_CPU_RD_BIT];
        end else if (ctrl_wr) begin
            entry_en_ff <= hwdata_i[otp_access_pkg::CTRL_ENTRY_BIT];
            cpu_rd_ff   <= hwdata_i[otp_access_pkg::CTRL_CPU_RD_BIT];
        end
    end

    // read mux; unmapped offsets read zero
    wire [31:0] rd_ctrl   = {30'h0000_0000, cpu_rd_ff, entry_en_ff};
    wire [31:0] rd_status = {wr_count_ff, 13'h0000, supply_on_s, armed_ff, prog_mode_ff};
    wire [31:0] rd_addr   = {23'h00_0000, last_addr_ff};
    wire [31:0] rd_data   = {16'h0000, 16'h0000};
    always_comb begin
        case (dp_addr_ff)
            otp_access_pkg::REG_CTRL_OFFSET:   hrdata_o = rd_ctrl;
            otp_access_pkg::REG_STATUS_OFFSET: hrdata_o = rd_status;
            otp_access_pkg::REG_ADDR_OFFSET:   hrdata_o = rd_addr;
            otp_access_pkg::REG_DATA_OFFSET:   hrdata_o = rd_data;
            default:                           hrdata_o = 32'h0000_0000;
        endcase
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

endmodule : otp_program_memory_access

// File: dv/otp_access_monitor.sv
// checker: port assertions for the one-time memory access block
module otp_access_monitor (
    // clocks and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        addr_step_clock_pin_i,
    // ahb-lite
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    // programming pins
    input wire logic        prog_supply_i,
    input wire logic [2:0]  open_drain_port_b_i,
    input wire logic        osc_second_pin_i,
    input wire logic [3:0]  push_pull_port_c_oe_o,
    input wire logic [3:0]  push_pull_port_d_oe_o,
    input wire logic        prog_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // helper: read of the data slot
    // ****
    wire  zero_rd;
    logic zero_rd_ff;
    assign zero_rd = hsel_i & hready_i & ~hwrite_i & (htrans_i == otp_access_pkg::HTRANS_NONSEQ)
                     & (haddr_i[7:0] == otp_access_pkg::REG_DATA_OFFSET);
    // carried into the data phase
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            zero_rd_ff <= 1'b0;
        end else begin
            zero_rd_ff <= zero_rd;
        end
    end

    // ****
    // assertions
    // ****
    // zero wait states, okay only, data slot reads zero
    hready_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) hreadyout_o)
        else $error("hreadyout low");
    resp_okay_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) !hresp_o)
        else $error("hresp not okay");
    zero_slot_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) zero_rd_ff |-> hrdata_o == '0)
        else $error("data slot not zero");
    // both nibbles turn round together
    oe_pair_a: assert property (@(posedge addr_step_clock_pin_i) disable iff (rst_i)
        push_pull_port_c_oe_o == push_pull_port_d_oe_o) else $error("byte lanes split");
    oe_nibble_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        push_pull_port_c_oe_o inside {4'h0, 4'hF}) else $error("partial lane drive");
    // only verify may drive; write needs the bus free for the programmer
    oe_verify_a: assert property (@(posedge addr_step_clock_pin_i) disable iff (rst_i)
        |push_pull_port_c_oe_o |-> {osc_second_pin_i, open_drain_port_b_i} == otp_access_pkg::MODE_VERIFY_CODE)
        else $error("bus driven outside verify");
    // mode follows the synchronised supply
    mode_rise_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(prog_mode_o) |-> prog_supply_i && $past(prog_supply_i, 2)) else $error("entry without supply");
    mode_fall_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(prog_supply_i) |-> ##[1:6] !prog_mode_o) else $error("mode kept after supply drop");
    mode_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        prog_mode_o && prog_supply_i |=> prog_mode_o) else $error("mode lost with supply on");
endmodule : otp_access_monitor

bind otp_program_memory_access otp_access_monitor u_mon (
    .clk_sys_i, .rst_i, .addr_step_clock_pin_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .prog_supply_i, .open_drain_port_b_i,
    .osc_second_pin_i, .push_pull_port_c_oe_o, .push_pull_port_d_oe_o, .prog_mode_o
);

// File: dv/otp_prog_model.sv
// model: external programmer driving supply, mode pins, step clock and data bus
module otp_prog_model (
    // supply and reset pin levels
    output logic            reset_pin_n_o,
    output logic            supply_o,
    // step clock and mode pins
    output logic            step_clk_o,
    output logic [2:0]      port_b_o,
    output logic            sel3_o,
    // resolved bus as the device sees it
    output logic [3:0]      bus_c_o,
    output logic [3:0]      bus_d_o,
    // device side of the bus
    input  wire logic [3:0] dev_c_i,
    input  wire logic [3:0] dev_c_oe_i,
    input  wire logic [3:0] dev_d_i,
    input  wire logic [3:0] dev_d_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv_val;
    logic       drv_en;
    logic [7:0] seen;
    // device lanes win; released lanes fall to the pull-down
    assign bus_c_o = (dev_c_oe_i & dev_c_i) | (~dev_c_oe_i & drv_val[7:4] & {4{drv_en}});
    assign bus_d_o = (dev_d_oe_i & dev_d_i) | (~dev_d_oe_i & drv_val[3:0] & {4{drv_en}});
    // power-on: clock low, reset held, supply off, clear selected
    initial begin
        step_clk_o = 1'b0;
        reset_pin_n_o = 1'b0;
        supply_o = 1'b0;
        {sel3_o, port_b_o} = otp_access_pkg::MODE_CLEAR_CODE;
        drv_en = 1'b0;
        drv_val = 8'h00;
    end
    // 3 ns high pulse after 3 ns low; clock stands low between pulses
    task automatic pulse();
        #3 step_clk_o = 1'b1;
        #2 seen = {bus_c_o, bus_d_o};
        #1 step_clk_o = 1'b0;
    endtask : pulse
    task automatic set_mode(input logic [3:0] m);
        {sel3_o, port_b_o} = m;
    endtask : set_mode
    // supply switched only with clear selected
    task automatic supply(input logic on);
        set_mode(otp_access_pkg::MODE_CLEAR_CODE);
        if (on) begin
            #10_010;
        end
        supply_o = on;
    endtask : supply
    // high byte on the first pulse, low byte on the second
    task automatic write_word(input logic [15:0] w);
        set_mode(otp_access_pkg::MODE_WRITE_CODE);
        drv_en = 1'b1;
        drv_val = w[15:8];
        pulse();
        drv_val = w[7:0];
        pulse();
        // write pulse time, then two idle pulses finish the word's four steps
        #400;
        drv_en = 1'b0;
        repeat (2) pulse();
        set_mode(otp_access_pkg::MODE_INHIBIT_CODE);
    endtask : write_word
    task automatic read_word(output logic [15:0] w);
        set_mode(otp_access_pkg::MODE_VERIFY_CODE);
        pulse();
        w[15:8] = seen;
        repeat (2) pulse();
        w[7:0] = seen;
        pulse();
        set_mode(otp_access_pkg::MODE_INHIBIT_CODE);
    endtask : read_word
endmodule : otp_prog_model

// File: dv/otp_program_memory_access_tb.sv
// testbench: register access and a write/verify session through the programmer model
module otp_program_memory_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 512;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] rdata;
    logic [31:0] wv;
    logic [15:0] got;
    logic [15:0] words [N];
    wire  [31:0] hrdata;
    wire         hrdy, hresp, pmode, rpin_n, sup, sclk, sel3;
    wire  [2:0]  pb;
    wire  [3:0]  cin, co, coe, din, dout, doe;
    int          n_fail = 0;
    int          comparisons = 0;
    int          i, k;

    always #20 clk = ~clk;

    otp_program_memory_access #(.RESET_HOLD(4)) u_dut (
        .clk_sys_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .reset_pin_n_i(rpin_n), .prog_supply_i(sup), .addr_step_clock_pin_i(sclk),
        .open_drain_port_b_i(pb), .osc_second_pin_i(sel3),
        .push_pull_port_c_i(cin), .push_pull_port_c_o(co), .push_pull_port_c_oe_o(coe),
        .push_pull_port_d_i(din), .push_pull_port_d_o(dout), .push_pull_port_d_oe_o(doe),
        .prog_mode_o(pmode));
    otp_prog_model u_prog (
        .reset_pin_n_o(rpin_n), .supply_o(sup), .step_clk_o(sclk), .port_b_o(pb), .sel3_o(sel3),
        .bus_c_o(cin), .bus_d_o(din), .dev_c_i(co), .dev_c_oe_i(coe), .dev_d_i(dout), .dev_d_oe_i(doe));

    // expected register contents
    function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
        return {30'h0, w[1:0]};
    endfunction : exp_ctrl
    function automatic logic [31:0] exp_status(input int n);
        return {n[15:0], 16'h0001};
    endfunction : exp_status
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // single word: address phase, then data phase, each held until hready
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= otp_access_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        for (k = 0; k < 50 && hrdy !== 1'b1; k++) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        for (k = 0; k < 50 && hrdy !== 1'b1; k++) @(posedge clk);
        rdata = hrdata;
    endtask : ahb
    task automatic complete_run();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // watchdog: the session needs a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        void'($urandom(51255));
        for (i = 0; i < N; i++) words[i] = 16'($urandom);
        words[0] = 16'h0000;
        words[1] = 16'hFFFF;
        wv = $urandom | 32'h0000_0001;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // ****
        // registers: reset value, write-ignored slot, unmapped, read back
        // ****
        ahb(1'b0, otp_access_pkg::REG_CTRL_OFFSET, '0);
        chk(rdata, 32'h0000_0000);
        ahb(1'b1, otp_access_pkg::REG_DATA_OFFSET, 32'hFFFF_FFFF);
        ahb(1'b0, otp_access_pkg::REG_DATA_OFFSET, '0);
        chk(rdata, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0040, '0);
        chk(rdata, 32'h0000_0000);
        ahb(1'b1, otp_access_pkg::REG_CTRL_OFFSET, wv);
        ahb(1'b0, otp_access_pkg::REG_CTRL_OFFSET, '0);
        chk(rdata, exp_ctrl(wv));
        ahb(1'b0, otp_access_pkg::REG_STATUS_OFFSET, '0);
        chk(rdata & 32'h0000_0001, 32'h0000_0000);
        // ****
        // entry, write, verify with an inhibit skip
        // ****
        u_prog.supply(1'b1);
        for (k = 0; k < 20 && pmode !== 1'b1; k++) @(posedge clk);
        chk({31'h0, pmode}, 32'h0000_0001);
        repeat (2) u_prog.pulse();
        u_prog.set_mode(otp_access_pkg::MODE_INHIBIT_CODE);
        for (i = 0; i < N; i++) u_prog.write_word(words[i]);
        u_prog.set_mode(otp_access_pkg::MODE_CLEAR_CODE);
        u_prog.pulse();
        u_prog.set_mode(otp_access_pkg::MODE_INHIBIT_CODE);
        u_prog.read_word(got);
        chk({16'h0, got}, {16'h0, words[0]});
        u_prog.set_mode(4'hF);
        repeat (4) u_prog.pulse();
        for (i = 2; i < N; i++) begin
            u_prog.read_word(got);
            chk({16'h0, got}, {16'h0, words[i]});
        end
        repeat (4) @(posedge clk);
        ahb(1'b0, otp_access_pkg::REG_STATUS_OFFSET, '0);
        chk(rdata & 32'hFFFF_0001, exp_status(N));
        ahb(1'b0, otp_access_pkg::REG_ADDR_OFFSET, '0);
        chk(rdata, 32'(N - 1));
        u_prog.supply(1'b0);
        for (k = 0; k < 20 && pmode !== 1'b0; k++) @(posedge clk);
        chk({31'h0, pmode}, 32'h0000_0000);
        complete_run();
    end
endmodule : otp_program_memory_access_tb
